/* compare_defines.svh */
// Constants for the less-than / less-or-equal compare unit.
// Assumes 32-bit instruction words with the opcode in the low six bits.
`ifndef COMPARE_DEFINES_SVH
`define COMPARE_DEFINES_SVH

`define CMP_WORD_W 32
`define CMP_IDX_W 5
`define CMP_IMM_W 16
`define CMP_OP_LSB 0
`define CMP_OP_W 6
`define CMP_A_LSB 27
`define CMP_B_LSB 22
`define CMP_C_LSB 17
`define CMP_OPX_LSB 11
`define CMP_OPX_W 6
`define CMP_IMM_LSB 6
`define CMP_OP_RTYPE 6'h3a
`define CMP_OPX_LT 6'h10
`define CMP_OP_LTI 6'h10
`define CMP_OP_LTUI 6'h30
`define CMP_IMM_INC 32'h0000_0001
`define CMP_TRUE 32'h0000_0001
`define CMP_FALSE 32'h0000_0000

`endif

/* compare_pkg.sv */
// Types shared by the compare unit and its users.
// Assumes nothing beyond the defines header.
package compare_pkg;

  // Less-or-equal forms that have no opcode of their own
  typedef enum logic [3:0] {
    le_signed_reg = 4'b0001,
    le_signed_imm = 4'b0010,
    le_unsigned_reg = 4'b0100,
    le_unsigned_imm = 4'b1000
  } le_kind_e;

endpackage

/* le_assertions.sv */
// Checker for the compare unit: results against decoded requests.
// Assumes binding to the unit's ports, one-cycle answer.
`timescale 1ns/1ps
`include "compare_defines.svh"
module le_checker #(
  parameter int WORD_W = 32,
  parameter int IDX_W = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic pseudo_valid,
  input wire compare_pkg::le_kind_e pseudo_kind,
  input wire logic [WORD_W-1:0] asm_immediate,
  input wire logic [WORD_W-1:0] first_source_value,
  input wire logic [WORD_W-1:0] second_source_value,
  input wire logic result_valid,
  input wire logic [IDX_W-1:0] dest_reg,
  input wire logic [WORD_W-1:0] result_data,
  input wire logic decode_miss
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic nat, lt_r, lti, ltui, e_lt, e_lti, e_ltui, e_sle, e_ule, e_sli, e_uli;
  logic p_sr, p_si, p_ur, p_ui;
  logic [15:0] inc;
  logic [4:0] c_idx, b_idx;
  logic [31:0] f, s;
  assign f = first_source_value;
  assign s = second_source_value;
  assign c_idx = instr_word[21:17];
  assign b_idx = instr_word[26:22];
  assign nat = instr_valid && !pseudo_valid;
  assign lt_r = nat && instr_word[5:0] == `CMP_OP_RTYPE && instr_word[16:11] == `CMP_OPX_LT;
  assign lti = nat && instr_word[5:0] == `CMP_OP_LTI;
  assign ltui = nat && instr_word[5:0] == `CMP_OP_LTUI;
  assign inc = asm_immediate[15:0] + 16'h1;
  assign e_lt = $signed(f) < $signed(s);
  assign e_lti = $signed(f) < $signed({{16{instr_word[21]}}, instr_word[21:6]});
  assign e_ltui = f < {16'h0, instr_word[21:6]};
  assign e_sle = $signed(f) <= $signed(s);
  assign e_ule = f <= s;
  assign e_sli = $signed(f) < $signed({{16{inc[15]}}, inc});
  assign e_uli = f < {16'h0, inc};
  assign p_sr = pseudo_valid && pseudo_kind == compare_pkg::le_signed_reg;
  assign p_si = pseudo_valid && pseudo_kind == compare_pkg::le_signed_imm;
  assign p_ur = pseudo_valid && pseudo_kind == compare_pkg::le_unsigned_reg;
  assign p_ui = pseudo_valid && pseudo_kind == compare_pkg::le_unsigned_imm;
  a_lt_reg: assert property (lt_r |=> result_valid
    && dest_reg == $past(c_idx) && result_data == {31'h0, $past(e_lt)})
    else $error("signed less-than wrong");
  a_lti_imm: assert property (lti |=> dest_reg == $past(b_idx)
    && result_data == {31'h0, $past(e_lti)}) else $error("signed imm less-than wrong");
  a_ltui_imm: assert property (ltui |=> dest_reg == $past(b_idx)
    && result_data == {31'h0, $past(e_ltui)}) else $error("unsigned imm less-than wrong");
  a_le_sreg: assert property (p_sr |=> result_valid
    && result_data[0] == $past(e_sle)) else $error("signed reg le wrong");
  a_le_simm: assert property (p_si |=> result_valid
    && result_data[0] == $past(e_sli)) else $error("signed imm le wrong");
  a_le_ureg: assert property (p_ur |=> result_valid
    && result_data[0] == $past(e_ule)) else $error("unsigned reg le wrong");
  a_le_uimm: assert property (p_ui |=> result_valid
    && result_data[0] == $past(e_uli)) else $error("unsigned imm le wrong");
  a_upper_clear: assert property (result_valid |-> result_data[31:1] == 31'h0)
    else $error("result upper bits set");
  a_miss_decode: assert property (nat && !(lt_r || lti || ltui) |=> decode_miss
    && !result_valid) else $error("non-compare word not refused");
endmodule // le_checker
bind less_equal_compare_unit le_checker #(.WORD_W(WORD_W), .IDX_W(IDX_W)) u_chk (
  .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
  .pseudo_valid(pseudo_valid), .pseudo_kind(pseudo_kind), .asm_immediate(asm_immediate),
  .first_source_value(first_source_value), .second_source_value(second_source_value),
  .result_valid(result_valid), .dest_reg(dest_reg), .result_data(result_data),
  .decode_miss(decode_miss));

/* less_equal_compare_unit.sv */
// Less-than and less-or-equal compare unit: decodes native compares and
// maps less-or-equal forms onto them, writing a one-word result.
// Assumes register values for the named indices arrive with each request,
// and that the register file consumes the registered write port.
// Assumes requests may come every cycle; each answer follows one clock later.
// Assumes the caller keeps mapped immediates inside their legal ranges.
`timescale 1ns/1ps
`include "compare_defines.svh"

module less_equal_compare_unit #(
  parameter int WORD_W = `CMP_WORD_W,
  parameter int IDX_W = `CMP_IDX_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic pseudo_valid,
  input wire compare_pkg::le_kind_e pseudo_kind,
  input wire logic [IDX_W-1:0] pseudo_first_idx,
  input wire logic [IDX_W-1:0] pseudo_second_idx,
  input wire logic [IDX_W-1:0] pseudo_dest_idx,
  input wire logic [WORD_W-1:0] asm_immediate,
  input wire logic [WORD_W-1:0] first_source_value,
  input wire logic [WORD_W-1:0] second_source_value,
  output logic result_valid,
  output logic [IDX_W-1:0] dest_reg,
  output logic [WORD_W-1:0] result_data,
  output logic decode_miss
);

  // Native compares this unit decodes; every other word without a pseudo request is refused
  typedef enum logic [3:0] {
    native_none = 4'b0001,
    native_lt_reg = 4'b0010,
    native_lt_imm = 4'b0100,
    native_ltu_imm = 4'b1000
  } native_op_e;

  logic [`CMP_OP_W-1:0] opcode;
  logic [`CMP_OPX_W-1:0] ext_opcode;
  logic [IDX_W-1:0] first_source_reg;
  logic [IDX_W-1:0] second_reg_field;
  logic [IDX_W-1:0] r_dest_field;
  logic [`CMP_IMM_W-1:0] imm_field_16;
  logic [`CMP_IMM_W-1:0] pseudo_imm_16;
  logic [WORD_W-1:0] inc_immediate;
  logic [WORD_W-1:0] cmp_left;
  logic [WORD_W-1:0] cmp_right;
  logic cmp_signed;
  logic cmp_invert;
  logic cmp_less;
  logic hit;
  logic [IDX_W-1:0] hit_dest;
  logic next_result_valid;
  logic [IDX_W-1:0] next_dest_reg;
  logic [WORD_W-1:0] next_result_data;
  logic next_decode_miss;
  // Native decode and pseudo validity
  native_op_e native_op;
  logic pseudo_known;

  // Immediate extension, used by native and mapped immediate forms
  function automatic logic [WORD_W-1:0] extend_imm(input logic [`CMP_IMM_W-1:0] imm,
                                                   input logic sign);
    extend_imm = {{(WORD_W-`CMP_IMM_W){sign & imm[`CMP_IMM_W-1]}}, imm};
  endfunction

  // Native opcode decode
  function automatic native_op_e decode_native(input logic [`CMP_OP_W-1:0] op,
                                               input logic [`CMP_OPX_W-1:0] opx);
    if (op == `CMP_OP_RTYPE && opx == `CMP_OPX_LT) begin
      decode_native = native_lt_reg;
    end else if (op == `CMP_OP_LTI) begin
      decode_native = native_lt_imm;
    end else if (op == `CMP_OP_LTUI) begin
      decode_native = native_ltu_imm;
    end else begin
      decode_native = native_none;
    end
  endfunction

  // Pseudo kinds that map onto a native compare
  function automatic logic le_kind_known(input compare_pkg::le_kind_e kind);
    le_kind_known = kind inside {compare_pkg::le_signed_reg, compare_pkg::le_signed_imm,
                                 compare_pkg::le_unsigned_reg, compare_pkg::le_unsigned_imm};
  endfunction

  // Field extraction
  assign opcode = instr_word[`CMP_OP_LSB +: `CMP_OP_W];
  assign ext_opcode = instr_word[`CMP_OPX_LSB +: `CMP_OPX_W];
  assign first_source_reg = instr_word[`CMP_A_LSB +: IDX_W];
  assign second_reg_field = instr_word[`CMP_B_LSB +: IDX_W];
  assign r_dest_field = instr_word[`CMP_C_LSB +: IDX_W];
  assign imm_field_16 = instr_word[`CMP_IMM_LSB +: `CMP_IMM_W];
  // Immediate plus one for the mapped immediate forms
  assign inc_immediate = asm_immediate + `CMP_IMM_INC;
  assign pseudo_imm_16 = inc_immediate[`CMP_IMM_W-1:0];
  assign native_op = decode_native(opcode, ext_opcode);
  assign pseudo_known = le_kind_known(pseudo_kind);

  // Shared magnitude comparator for every form
  magnitude_compare #(
    .WIDTH(WORD_W)
  ) u_compare (
    .left(cmp_left),
    .right(cmp_right),
    .is_signed(cmp_signed),
    .less(cmp_less)
  );

  // Operand steering and decode
  always_comb begin
    cmp_left = first_source_value;
    cmp_right = second_source_value;
    cmp_signed = 1'b1;
    cmp_invert = 1'b0;
    hit = 1'b0;
    hit_dest = '0;
    // Pseudo requests win over native words in the same cycle
    if (pseudo_valid) begin
      // Register forms swap operands and invert the strict result
      unique case (pseudo_kind)
        compare_pkg::le_signed_reg: begin
          cmp_left = second_source_value;
          cmp_right = first_source_value;
          cmp_invert = 1'b1;
        end
        // Immediate forms compare against the incremented immediate
        compare_pkg::le_signed_imm: begin
          cmp_right = extend_imm(pseudo_imm_16, 1'b1);
        end
        compare_pkg::le_unsigned_reg: begin
          cmp_left = second_source_value;
          cmp_right = first_source_value;
          cmp_signed = 1'b0;
          cmp_invert = 1'b1;
        end
        compare_pkg::le_unsigned_imm: begin
          cmp_right = extend_imm(pseudo_imm_16, 1'b0);
          cmp_signed = 1'b0;
        end
        default: begin
          cmp_signed = 1'b1;
        end
      endcase
      hit = pseudo_known;
      hit_dest = pseudo_dest_idx;
    end else if (instr_valid) begin
      unique case (native_op)
        native_lt_reg: begin
          hit = 1'b1;
          hit_dest = r_dest_field;
        end
        native_lt_imm: begin
          cmp_right = extend_imm(imm_field_16, 1'b1);
          hit = 1'b1;
          hit_dest = second_reg_field;
        end
        native_ltu_imm: begin
          cmp_right = extend_imm(imm_field_16, 1'b0);
          cmp_signed = 1'b0;
          hit = 1'b1;
          hit_dest = second_reg_field;
        end
        native_none: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // Result word and write port next values
  always_comb begin
    next_result_valid = hit;
    next_dest_reg = hit_dest;
    // Miss pulse: a valid request that no compare here serves
    if (pseudo_valid) begin
      next_decode_miss = ~pseudo_known;
    end else begin
      next_decode_miss = instr_valid & (native_op == native_none);
    end
    next_result_data = (cmp_less ^ cmp_invert) ? `CMP_TRUE : `CMP_FALSE;
    if (!hit) begin
      next_result_data = `CMP_FALSE;
    end
  end

  // Registered write port
  always_ff @(posedge clock) begin
    if (rst) begin
      result_valid <= 1'b0;
      dest_reg <= '0;
      result_data <= `CMP_FALSE;
      decode_miss <= 1'b0;
    end else begin
      result_valid <= next_result_valid;
      dest_reg <= next_dest_reg;
      result_data <= next_result_data;
      decode_miss <= next_decode_miss;
    end
  end

  // Unused fields of the full instruction word are ignored by design
  logic unused_first_idx;
  assign unused_first_idx = ^{first_source_reg, pseudo_first_idx, pseudo_second_idx};

endmodule // less_equal_compare_unit

/* less_equal_compare_unit_tb_top.sv */
// Testbench: random native and less-or-equal compares scored from a queue.
// Assumes one answer per request, one cycle after it is taken.
`timescale 1ns/1ps
`include "compare_defines.svh"
module less_equal_compare_unit_tb_top;
  typedef struct {logic miss; logic [4:0] dest; logic [31:0] data;} note_s;
  note_s notes[$];
  note_s n, m;
  logic clock = 0, rst = 1, instr_valid = 0, pseudo_valid = 0, bit_e, result_valid, decode_miss;
  logic [31:0] instr_word = 0, asm_immediate = 0, first_source_value = 0, second_source_value = 0;
  logic [4:0] pseudo_dest_idx = 0, pseudo_first_idx = 0, pseudo_second_idx = 0, dest_reg;
  logic [31:0] result_data, r, w, a, b, si, ui;
  logic [15:0] x;
  compare_pkg::le_kind_e pseudo_kind = compare_pkg::le_signed_reg;
  int fails = 0, n_tests = 0, seed = 8980, k;
  less_equal_compare_unit dut (.clock(clock), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .pseudo_valid(pseudo_valid), .pseudo_kind(pseudo_kind),
    .pseudo_first_idx(pseudo_first_idx), .pseudo_second_idx(pseudo_second_idx),
    .pseudo_dest_idx(pseudo_dest_idx), .asm_immediate(asm_immediate),
    .first_source_value(first_source_value), .second_source_value(second_source_value),
    .result_valid(result_valid), .dest_reg(dest_reg), .result_data(result_data),
    .decode_miss(decode_miss));
  initial forever #50 clock = ~clock;
  function automatic logic [31:0] pick(input logic [2:0] c);
    pick = c == 0 ? 32'h0 : c == 1 ? 32'h7fffffff : c == 2 ? 32'h80000000 : $random(seed);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge clock) begin
    if (!rst && (result_valid !== 1'b0 || decode_miss !== 1'b0)) begin
      m.miss = 1'b1;
      m.dest = 5'h00;
      m.data = 32'hffffffff;
      if (notes.size() > 0) m = notes.pop_front();
      check("miss", {31'h0, m.miss}, {31'h0, decode_miss});
      check("valid", {31'h0, !m.miss}, {31'h0, result_valid});
      if (!m.miss) check("dest", {27'h0, m.dest}, {27'h0, dest_reg});
      check("data", m.data, result_data);
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 450; i++) begin
      @(posedge clock);
      r = $random(seed);
      k = i % 9;
      x = (r[31:16] == 16'h7fff) ? 16'h7ffe : r[31:16];
      si = r[5] ? {{16{x[15]}}, x} : r[4] ? 32'h00007ffe : 32'hffff7fff;
      ui = r[5] ? {16'h0, &x ? 16'hfffe : x} : r[4] ? 32'h0000fffe : 32'h0;
      a = r[6] && k == 5 ? si : r[6] && k == 7 ? ui : pick(r[2:0]);
      b = r[3] ? a : pick(r[9:7]);
      w = $random(seed);
      w[5:0] = r[0] ? 6'h28 : 6'h3a;
      if (k < 3) w[5:0] = k == 0 ? `CMP_OP_RTYPE : k == 1 ? `CMP_OP_LTI : `CMP_OP_LTUI;
      if (k == 0 || k == 3) w[16:11] = k == 0 ? `CMP_OPX_LT : 6'h30;
      n.miss = k == 3;
      n.dest = k == 0 ? w[21:17] : k < 3 ? w[26:22] : r[14:10];
      case (k)
        0: bit_e = $signed(a) < $signed(b);
        1: bit_e = $signed(a) < $signed({{16{w[21]}}, w[21:6]});
        2: bit_e = a < {16'h0, w[21:6]};
        4: bit_e = $signed(a) <= $signed(b);
        5: bit_e = $signed(a) <= $signed(si);
        6: bit_e = a <= b;
        7: bit_e = a <= ui;
        default: bit_e = 1'b0;
      endcase
      n.data = {31'h0, bit_e};
      instr_valid <= k < 4 || (k < 8 && r[15]);
      pseudo_valid <= k >= 4 && k < 8;
      pseudo_kind <= compare_pkg::le_kind_e'(4'h1 << (k % 4));
      instr_word <= w;
      first_source_value <= a;
      second_source_value <= b;
      asm_immediate <= k == 7 ? ui : si;
      pseudo_dest_idx <= r[14:10];
      pseudo_first_idx <= w[31:27];
      pseudo_second_idx <= w[26:22];
      if (k < 8) notes.push_back(n);
    end
    @(posedge clock);
    instr_valid <= 1'b0;
    pseudo_valid <= 1'b0;
    repeat (3) @(posedge clock);
    check("pending", 32'h0, notes.size());
    report_and_stop();
  end
endmodule // less_equal_compare_unit_tb_top

/* magnitude_compare.sv */
// Combinational 32-bit less-than comparator, signed or unsigned.
// Assumes operands are already extended to full width.
`timescale 1ns/1ps
`include "compare_defines.svh"

module magnitude_compare #(
  parameter int WIDTH = `CMP_WORD_W
) (
  input wire logic [WIDTH-1:0] left,
  input wire logic [WIDTH-1:0] right,
  input wire logic is_signed,
  output logic less
);

  always_comb begin
    if (is_signed) begin
      less = $signed(left) < $signed(right);
    end else begin
      less = left < right;
    end
  end

endmodule // magnitude_compare
